/* verilog/fsf_defines.svh */
// Constants for the flash supervisory call sequencer.
`ifndef FSF_DEFINES_SVH
`define FSF_DEFINES_SVH
`define FSF_FIRST_KEY_PARAM_VAL   8'h3A
`define FSF_SECOND_KEY_PARAM_ADJ   8'h03
`define FSF_PRM_BASE   8'hF8
`define FSF_PROT_SRAM  8'h80
`define FSF_PRM_LAST   14'h0008
`define FSF_BLK_LAST   6'h3F
`define FSF_PROT_LAST  14'h003F
`define FSF_TBL_LAST   14'h0007
`define FSF_STEP_LAST  14'h0002
`define FSF_FN_BOOT    8'h00
`define FSF_FN_PROT    8'h04
`define FSF_FN_ERASE   8'h05
`define FSF_FN_TABLE   8'h06
`define FSF_FN_CSUM    8'h07
`define FSF_TBL_SILID  3'h0
`define FSF_TBL_TRIM   3'h1
`define FSF_X_TRIM     8'hFF
`define FSF_MACRO_W    2
`define FSF_ADDR_W     14
`endif

/* verilog/fsf_pkg.sv */
// Types for the flash supervisory call sequencer.
`include "fsf_defines.svh"
package fsf_pkg;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h00,
    ST_PRM    = 5'h01,
    ST_CHK    = 5'h02,
    ST_SRW    = 5'h03,
    ST_FLW    = 5'h04,
    ST_PR_SRD = 5'h05,
    ST_PR_FRD = 5'h06,
    ST_PR_FWR = 5'h07,
    ST_PR_NXT = 5'h08,
    ST_EA_USR = 5'h09,
    ST_EA_USN = 5'h0A,
    ST_EA_PER = 5'h0B,
    ST_EA_PWR = 5'h0C,
    ST_EA_PNX = 5'h0D,
    ST_TB_RD  = 5'h0E,
    ST_TB_WR  = 5'h0F,
    ST_CS_RD  = 5'h10,
    ST_CS_ADD = 5'h11,
    ST_FIN    = 5'h12,
    ST_FIN2   = 5'h13,
    ST_DONE   = 5'h14,
    ST_HALT   = 5'h15
  } fsf_state_t;
  typedef enum logic [2:0] {
    FC_NONE   = 3'h0,
    FC_USR_RD = 3'h1,
    FC_ER_USR = 3'h2,
    FC_PG_ZRO = 3'h3,
    FC_ER_PRT = 3'h4,
    FC_PRT_RD = 3'h5,
    FC_PRT_WR = 3'h6,
    FC_TBL_RD = 3'h7
  } fsf_fcmd_t;
  typedef struct packed {
    logic                     start;
    fsf_fcmd_t                cmd;
    logic [`FSF_MACRO_W-1:0]  macro;
    logic [`FSF_ADDR_W-1:0]   addr;
    logic [7:0]               wdata;
    logic [7:0]               clk_div;
    logic [7:0]               delay;
  } fsf_flash_req_t;
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fsf_sram_req_t;
endpackage

/* verilog/fsf_supervisor.sv */
// Flash supervisory call sequencer: protect, full erase, table fetch, checksum.
`timescale 1ns/1ps
`include "fsf_defines.svh"
module fsf_supervisor #(
  parameter int          NUM_MACROS = 1,
  parameter logic [15:0] REV_ID     = 16'h0000, // Arbitrary value.
  parameter logic [7:0]  REV_COUNT  = 8'h00     // Arbitrary value.
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   call_req,
  input  wire logic [7:0]             call_func,
  input  wire logic [7:0]             call_sp,
  input  wire logic [7:0]             sram_rdata,
  input  wire logic                   flash_done,
  input  wire logic [7:0]             flash_rdata,
  output      logic                   call_done,
  output      logic                   cpu_halted,
  output      logic [7:0]             acc_out,
  output      logic [7:0]             x_out,
  output      fsf_pkg::fsf_sram_req_t  sram_req,
  output      fsf_pkg::fsf_flash_req_t flash_req
);
  // ==========================================================
  // Declarations
  localparam logic [`FSF_MACRO_W-1:0] MAC_TOP = `FSF_MACRO_W'(NUM_MACROS - 1);
  fsf_pkg::fsf_state_t            st_r,   st_nxt;
  fsf_pkg::fsf_state_t            ret_r,  ret_nxt;
  logic [`FSF_ADDR_W-1:0]         cnt_r,  cnt_nxt;
  logic [`FSF_MACRO_W-1:0]        mac_r,  mac_nxt;
  logic [7:0]                     func_r, func_nxt;
  logic [7:0]                     exp2_r, exp2_nxt;
  logic [7:0]                     prm_r   [0:6];
  logic [7:0]                     prm_nxt [0:6];
  logic [7:0]                     dat_r,  dat_nxt;
  logic [7:0]                     fdat_r, fdat_nxt;
  logic [7:0]                     lo_r,   lo_nxt;
  logic [7:0]                     hi_r,   hi_nxt;
  logic [7:0]                     acc_r,  acc_nxt;
  logic [7:0]                     x_r,    x_nxt;
  logic                           done_r, done_nxt;
  logic                           halt_r, halt_nxt;
  fsf_pkg::fsf_sram_req_t         sr_r,   sr_nxt;
  fsf_pkg::fsf_flash_req_t        fl_r,   fl_nxt;
  logic [2:0]                     tbl;
  logic [`FSF_ADDR_W-1:0]         cs_last;
  logic [8:0]                     sum9;

  // ==========================================================
  // Flash request builder
  // Every flash step goes through this so the pulse settings always ride along.
  function automatic fsf_pkg::fsf_flash_req_t fl_op(
    input fsf_pkg::fsf_flash_req_t  base,
    input fsf_pkg::fsf_fcmd_t       cmd,
    input logic [`FSF_MACRO_W-1:0]  mac,
    input logic [`FSF_ADDR_W-1:0]   addr,
    input logic [7:0]               wdata
  );
    fsf_pkg::fsf_flash_req_t r;
    r       = base;
    r.start = 1'b1;
    r.cmd   = cmd;
    r.macro = mac;
    r.addr  = addr;
    r.wdata = wdata;
    return r;
  endfunction

  // ==========================================================
  // Derived values
  // Only three bits pick the table; the upper five are dropped.
  assign tbl     = prm_r[2][2:0];
  // Count 0 wraps to FFh so all 256 blocks of 64 bytes are summed.
  assign cs_last = {prm_r[2] - 8'h01, `FSF_BLK_LAST};
  assign sum9    = {1'b0, lo_r} + {1'b0, fdat_r};

  // ==========================================================
  // Sequencer next state
  always_comb begin
    st_nxt   = st_r;
    ret_nxt  = ret_r;
    cnt_nxt  = cnt_r;
    mac_nxt  = mac_r;
    func_nxt = func_r;
    exp2_nxt = exp2_r;
    for (int i = 0; i < 7; i++) begin
      prm_nxt[i] = prm_r[i];
    end
    dat_nxt  = dat_r;
    fdat_nxt = fdat_r;
    lo_nxt   = lo_r;
    hi_nxt   = hi_r;
    acc_nxt  = acc_r;
    x_nxt    = x_r;
    done_nxt = 1'b0;
    halt_nxt = halt_r;
    sr_nxt    = sr_r;
    sr_nxt.we = 1'b0;
    fl_nxt       = fl_r;
    fl_nxt.start = 1'b0;
    case (st_r)
      fsf_pkg::ST_IDLE: begin
        if (call_req) begin
          func_nxt = call_func;
          exp2_nxt = call_sp + `FSF_SECOND_KEY_PARAM_ADJ;
          cnt_nxt  = '0;
          lo_nxt   = 8'h00;
          hi_nxt   = 8'h00;
          st_nxt   = fsf_pkg::ST_PRM;
        end
      end
      // Parameter block fetch; SRAM data trails the address by two cycles.
      fsf_pkg::ST_PRM: begin
        sr_nxt.addr = `FSF_PRM_BASE + {5'h00, cnt_r[2:0]};
        if (cnt_r >= 14'h0002) begin
          prm_nxt[cnt_r[2:0] - 3'h2] = sram_rdata;
        end
        cnt_nxt = cnt_r + 14'h0001;
        if (cnt_r == `FSF_PRM_LAST) begin
          st_nxt = fsf_pkg::ST_CHK;
        end
      end
      // Key check; the boot code skips it since it is outside this block.
      fsf_pkg::ST_CHK: begin
        cnt_nxt        = '0;
        fl_nxt.clk_div = prm_r[4];
        fl_nxt.delay   = prm_r[6];
        if (func_r == `FSF_FN_BOOT) begin
          st_nxt = fsf_pkg::ST_DONE;
        end else if (prm_r[0] != `FSF_FIRST_KEY_PARAM_VAL || prm_r[1] != exp2_r) begin
          halt_nxt = 1'b1;
          st_nxt   = fsf_pkg::ST_HALT;
        end else begin
          case (func_r)
            `FSF_FN_PROT:  st_nxt = fsf_pkg::ST_PR_SRD;
            `FSF_FN_ERASE: begin
              mac_nxt = MAC_TOP;
              st_nxt  = fsf_pkg::ST_EA_USR;
            end
            `FSF_FN_TABLE: st_nxt = fsf_pkg::ST_TB_RD;
            `FSF_FN_CSUM:  st_nxt = fsf_pkg::ST_CS_RD;
            default:       st_nxt = fsf_pkg::ST_DONE;
          endcase
        end
      end
      fsf_pkg::ST_SRW: st_nxt = ret_r;
      // Waits out the whole flash pulse before moving on.
      fsf_pkg::ST_FLW: begin
        if (flash_done) begin
          fdat_nxt = flash_rdata;
          st_nxt   = ret_r;
        end
      end
      // Protect: byte n of the block covers blocks 4n..4n+3, bit pairs in place.
      fsf_pkg::ST_PR_SRD: begin
        sr_nxt.addr = `FSF_PROT_SRAM + cnt_r[7:0];
        ret_nxt     = fsf_pkg::ST_PR_FRD;
        st_nxt      = fsf_pkg::ST_SRW;
      end
      fsf_pkg::ST_PR_FRD: begin
        dat_nxt = sram_rdata;
        fl_nxt  = fl_op(fl_r, fsf_pkg::FC_PRT_RD, '0, cnt_r, 8'h00);
        ret_nxt = fsf_pkg::ST_PR_FWR;
        st_nxt  = fsf_pkg::ST_FLW;
      end
      // OR only ever raises the level; lowering is left to full erase.
      fsf_pkg::ST_PR_FWR: begin
        fl_nxt  = fl_op(fl_r, fsf_pkg::FC_PRT_WR, '0, cnt_r, dat_r | fdat_r);
        ret_nxt = fsf_pkg::ST_PR_NXT;
        st_nxt  = fsf_pkg::ST_FLW;
      end
      fsf_pkg::ST_PR_NXT: begin
        cnt_nxt = cnt_r + 14'h0001;
        st_nxt  = (cnt_r == `FSF_PROT_LAST) ? fsf_pkg::ST_FIN : fsf_pkg::ST_PR_SRD;
      end
      // Full erase, user space: erase, zero program, erase per macro.
      fsf_pkg::ST_EA_USR: begin
        fl_nxt  = fl_op(fl_r, (cnt_r == 14'h0001) ? fsf_pkg::FC_PG_ZRO : fsf_pkg::FC_ER_USR,
                        mac_r, '0, 8'h00);
        ret_nxt = fsf_pkg::ST_EA_USN;
        st_nxt  = fsf_pkg::ST_FLW;
      end
      fsf_pkg::ST_EA_USN: begin
        if (cnt_r != `FSF_STEP_LAST) begin
          cnt_nxt = cnt_r + 14'h0001;
          st_nxt  = fsf_pkg::ST_EA_USR;
        end else begin
          cnt_nxt = '0;
          if (mac_r == '0) begin
            mac_nxt = MAC_TOP;
            st_nxt  = fsf_pkg::ST_EA_PER;
          end else begin
            mac_nxt = mac_r - 1'b1;
            st_nxt  = fsf_pkg::ST_EA_USR;
          end
        end
      end
      // Protection erase addresses only the protection block, never the hidden ones.
      fsf_pkg::ST_EA_PER: begin
        fl_nxt  = fl_op(fl_r, fsf_pkg::FC_ER_PRT, mac_r, '0, 8'h00);
        ret_nxt = fsf_pkg::ST_EA_PWR;
        st_nxt  = fsf_pkg::ST_FLW;
      end
      fsf_pkg::ST_EA_PWR: begin
        fl_nxt  = fl_op(fl_r, fsf_pkg::FC_PRT_WR, mac_r, cnt_r, 8'h00);
        ret_nxt = fsf_pkg::ST_EA_PNX;
        st_nxt  = fsf_pkg::ST_FLW;
      end
      fsf_pkg::ST_EA_PNX: begin
        if (cnt_r != `FSF_PROT_LAST) begin
          cnt_nxt = cnt_r + 14'h0001;
          st_nxt  = fsf_pkg::ST_EA_PWR;
        end else begin
          cnt_nxt = '0;
          mac_nxt = mac_r - 1'b1;
          st_nxt  = (mac_r == '0) ? fsf_pkg::ST_FIN : fsf_pkg::ST_EA_PER;
        end
      end
      // Table fetch: row offset is table times eight plus byte.
      fsf_pkg::ST_TB_RD: begin
        fl_nxt  = fl_op(fl_r, fsf_pkg::FC_TBL_RD, '0, {8'h00, tbl, cnt_r[2:0]}, 8'h00);
        ret_nxt = fsf_pkg::ST_TB_WR;
        st_nxt  = fsf_pkg::ST_FLW;
      end
      // Silicon identifier and trims go to SRAM only.
      fsf_pkg::ST_TB_WR: begin
        sr_nxt.we    = 1'b1;
        sr_nxt.addr  = `FSF_PRM_BASE + {5'h00, cnt_r[2:0]};
        sr_nxt.wdata = fdat_r;
        cnt_nxt      = cnt_r + 14'h0001;
        st_nxt       = fsf_pkg::ST_TB_RD;
        if (cnt_r == `FSF_TBL_LAST) begin
          st_nxt = fsf_pkg::ST_DONE;
          if (tbl == `FSF_TBL_TRIM) begin
            acc_nxt = REV_COUNT;
            x_nxt   = `FSF_X_TRIM;
          end else begin
            acc_nxt = REV_ID[15:8];
            x_nxt   = REV_ID[7:0];
          end
        end
      end
      // Checksum over macro zero, one byte per flash read.
      fsf_pkg::ST_CS_RD: begin
        fl_nxt  = fl_op(fl_r, fsf_pkg::FC_USR_RD, '0, cnt_r, 8'h00);
        ret_nxt = fsf_pkg::ST_CS_ADD;
        st_nxt  = fsf_pkg::ST_FLW;
      end
      fsf_pkg::ST_CS_ADD: begin
        lo_nxt  = sum9[7:0];
        hi_nxt  = hi_r + {7'h00, sum9[8]};
        cnt_nxt = cnt_r + 14'h0001;
        st_nxt  = (cnt_r == cs_last) ? fsf_pkg::ST_FIN : fsf_pkg::ST_CS_RD;
      end
      // Low sum doubles as return code 00h for protect and full erase.
      fsf_pkg::ST_FIN: begin
        sr_nxt.we    = 1'b1;
        sr_nxt.addr  = `FSF_PRM_BASE;
        sr_nxt.wdata = lo_r;
        st_nxt       = (func_r == `FSF_FN_CSUM) ? fsf_pkg::ST_FIN2 : fsf_pkg::ST_DONE;
      end
      fsf_pkg::ST_FIN2: begin
        sr_nxt.we    = 1'b1;
        sr_nxt.addr  = `FSF_PRM_BASE + 8'h01;
        sr_nxt.wdata = hi_r;
        st_nxt       = fsf_pkg::ST_DONE;
      end
      fsf_pkg::ST_DONE: begin
        done_nxt = 1'b1;
        st_nxt   = fsf_pkg::ST_IDLE;
      end
      fsf_pkg::ST_HALT: st_nxt = fsf_pkg::ST_HALT;
      default:          st_nxt = fsf_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================
  // Sequencer registers
  // No block erase path exists here, so only full erase, which writes 00h to protection, can lower a level.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r   <= fsf_pkg::ST_IDLE;
      ret_r  <= fsf_pkg::ST_IDLE;
      cnt_r  <= '0;
      mac_r  <= '0;
      func_r <= 8'h00;
      exp2_r <= 8'h00;
      for (int i = 0; i < 7; i++) begin
        prm_r[i] <= 8'h00;
      end
      dat_r  <= 8'h00;
      fdat_r <= 8'h00;
      lo_r   <= 8'h00;
      hi_r   <= 8'h00;
      acc_r  <= 8'h00;
      x_r    <= 8'h00;
      done_r <= 1'b0;
      halt_r <= 1'b0;
      sr_r   <= '0;
      fl_r   <= '0;
    end else begin
      st_r   <= st_nxt;
      ret_r  <= ret_nxt;
      cnt_r  <= cnt_nxt;
      mac_r  <= mac_nxt;
      func_r <= func_nxt;
      exp2_r <= exp2_nxt;
      for (int i = 0; i < 7; i++) begin
        prm_r[i] <= prm_nxt[i];
      end
      dat_r  <= dat_nxt;
      fdat_r <= fdat_nxt;
      lo_r   <= lo_nxt;
      hi_r   <= hi_nxt;
      acc_r  <= acc_nxt;
      x_r    <= x_nxt;
      done_r <= done_nxt;
      halt_r <= halt_nxt;
      sr_r   <= sr_nxt;
      fl_r   <= fl_nxt;
    end
  end

  // Outputs are the registers themselves.
  assign call_done  = done_r;
  assign cpu_halted = halt_r;
  assign acc_out    = acc_r;
  assign x_out      = x_r;
  assign sram_req   = sr_r;
  assign flash_req  = fl_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [7:0]  or_val;
  logic [15:0] sum_exp;
  assign or_val  = dat_r | fdat_r;
  assign sum_exp = {hi_r, lo_r} + {8'h00, fdat_r};

  chk_prot_or_data: assert property ((st_r == fsf_pkg::ST_PR_FWR) |=>
    (fl_r.start && fl_r.cmd == fsf_pkg::FC_PRT_WR && fl_r.wdata == $past(or_val)))
    else $error("protect write is not the OR value");
  chk_prot_sram_base: assert property ((st_r == fsf_pkg::ST_PR_SRD) |=>
    (sr_r.addr == 8'h80 + $past(cnt_r[7:0])))
    else $error("protect data not read from 80h upward");
  chk_prot_erase_only: assert property ((fl_r.start && fl_r.cmd == fsf_pkg::FC_ER_PRT) |->
    (func_r == `FSF_FN_ERASE))
    else $error("protection erased outside full erase");
  chk_erase_zero_fill: assert property ((fl_r.start && fl_r.cmd == fsf_pkg::FC_PRT_WR &&
    func_r == `FSF_FN_ERASE) |-> (fl_r.wdata == 8'h00))
    else $error("full erase writes nonzero protection");
  chk_hidden_untouched: assert property ((fl_r.start && (fl_r.cmd == fsf_pkg::FC_ER_PRT ||
    fl_r.cmd == fsf_pkg::FC_PRT_WR)) |-> (fl_r.addr[13:6] == 8'h00))
    else $error("protection access outside protection block");
  chk_macro_descend: assert property ((st_r == fsf_pkg::ST_EA_USN && cnt_r == 14'h0002 &&
    mac_r != '0) |=> (mac_r == $past(mac_r) - 1'b1) ##1 (fl_r.cmd == fsf_pkg::FC_ER_USR))
    else $error("macros not erased downward");
  chk_table_select: assert property ((fl_r.start && fl_r.cmd == fsf_pkg::FC_TBL_RD) |->
    (fl_r.addr[5:3] == prm_r[2][2:0] && fl_r.addr[13:6] == 8'h00))
    else $error("table selected from wrong bits");
  chk_table_dest: assert property ((sr_r.we && func_r == `FSF_FN_TABLE) |->
    (sr_r.addr >= 8'hF8))
    else $error("table byte written outside F8h to FFh");
  chk_trim_index: assert property ((done_r && func_r == `FSF_FN_TABLE &&
    prm_r[2][2:0] == 3'h1) |-> (x_r == 8'hFF && acc_r == REV_COUNT))
    else $error("trim table return registers wrong");
  chk_sum_carry: assert property ((st_r == fsf_pkg::ST_CS_ADD) |=>
    ({hi_r, lo_r} == $past(sum_exp)))
    else $error("checksum carry not propagated");
  chk_bad_key_halt: assert property ((st_r == fsf_pkg::ST_CHK && func_r != 8'h00 &&
    prm_r[0] != 8'h3A) |=> (cpu_halted && !call_done)[*3])
    else $error("bad key did not halt");
  chk_done_after_flash: assert property ((st_r == fsf_pkg::ST_FLW && !flash_done) |=>
    (st_r == fsf_pkg::ST_FLW && !call_done))
    else $error("call moved on with a flash step pending");
  chk_prot_write_src: assert property ((fl_r.start && fl_r.cmd == fsf_pkg::FC_PRT_WR) |->
    (func_r == `FSF_FN_PROT || func_r == `FSF_FN_ERASE))
    else $error("protection written outside protect or full erase");

  cov_protect: cover property (done_r && func_r == `FSF_FN_PROT);
  cov_erase:   cover property (done_r && func_r == `FSF_FN_ERASE);
  cov_table:   cover property (done_r && func_r == `FSF_FN_TABLE);
  cov_csum:    cover property (done_r && func_r == `FSF_FN_CSUM);
  cov_halt:    cover property ($rose(halt_r));
endmodule // fsf_supervisor

/* verification/fsf_flash_model.sv */
// Behavioural SRAM and flash macros that stand behind the supervisory call sequencer.
`timescale 1ns/1ps
module fsf_flash_model (
  input  wire logic                    clk_sys,
  input  wire logic                    slow,
  input  wire fsf_pkg::fsf_sram_req_t  sram_req,
  input  wire fsf_pkg::fsf_flash_req_t flash_req,
  output      logic [7:0]              sram_rdata,
  output      logic                    flash_done,
  output      logic [7:0]              flash_rdata
);
  // ==========================================================
  // Storage
  logic [7:0]              sram [256];
  logic [7:0]              user [16384]; // Macro 0 only: 256 blocks of 64 bytes.
  logic [7:0]              prot [2][64];
  logic [7:0]              tbl  [64];    // Eight tables of eight bytes.
  logic [4:0]              log_q [$];
  fsf_pkg::fsf_flash_req_t req_r;
  logic                    busy;
  int                      wait_n;

  initial begin
    busy = 1'b0;
    flash_done = 1'b0;
    sram_rdata = 8'h00;
    flash_rdata = 8'h00;
  end

  // ==========================================================
  // SRAM with one cycle of read latency on the registered address.
  always @(posedge clk_sys) begin
    sram_rdata <= sram[sram_req.addr];
    if (sram_req.we) begin
      sram[sram_req.addr] <= sram_req.wdata;
    end
  end

  // ==========================================================
  // Flash steps; read data is noise outside a done pulse so stale bytes never pass.
  always @(posedge clk_sys) begin
    flash_done <= 1'b0;
    flash_rdata <= 8'($urandom);
    if (flash_req.start) begin
      busy <= 1'b1;
      req_r <= flash_req;
      wait_n <= slow ? int'($urandom % 4) : 0;
      if (flash_req.cmd inside {3'h2, 3'h3, 3'h4} || (flash_req.cmd == 3'h6 && flash_req.addr == 14'h0000)) begin
        log_q.push_back({flash_req.cmd, flash_req.macro});
      end
    end else if (busy && wait_n > 0) begin
      wait_n <= wait_n - 1;
    end else if (busy) begin
      busy <= 1'b0;
      flash_done <= 1'b1;
      case (req_r.cmd)
        3'h1: flash_rdata <= user[req_r.addr];
        3'h2: if (req_r.macro == 2'h0) for (int j = 0; j < 16384; j++) user[j] = 8'hFF;
        3'h3: if (req_r.macro == 2'h0) for (int j = 0; j < 16384; j++) user[j] = 8'h00;
        3'h4: for (int j = 0; j < 64; j++) prot[req_r.macro[0]][j] = 8'hFF;
        3'h5: flash_rdata <= prot[req_r.macro[0]][req_r.addr[5:0]];
        3'h6: prot[req_r.macro[0]][req_r.addr[5:0]] = req_r.wdata;
        3'h7: flash_rdata <= tbl[req_r.addr[5:0]];
        default: ;
      endcase
    end
  end
endmodule // fsf_flash_model

/* verification/fsf_supervisor_bench.sv */
// Self-checking bench for the flash supervisory call sequencer.
`timescale 1ns/1ps
`define CHK(g, e) check_eq(16'(g), 16'(e));
module fsf_supervisor_bench;
  localparam logic [15:0] REV_ID    = 16'h5A3C; // Arbitrary value.
  localparam logic [7:0]  REV_COUNT = 8'h07;    // Arbitrary value.
  logic                    clk_sys = 1'b0;
  logic                    rst = 1'b1;
  logic                    call_req = 1'b0;
  logic [7:0]              call_func = 8'h00;
  logic [7:0]              call_sp = 8'h00;
  logic                    slow = 1'b1;
  logic [7:0]              sram_rdata, flash_rdata, acc_out, x_out, clkv;
  logic                    flash_done, call_done, cpu_halted;
  fsf_pkg::fsf_sram_req_t  sram_req;
  fsf_pkg::fsf_flash_req_t flash_req;
  int                      fails = 0;
  int                      n_compared = 0;
  logic [7:0]              exp_b [64];
  logic [4:0]              exp_q [$];
  int                      bad;

  fsf_supervisor #(.NUM_MACROS(2), .REV_ID(REV_ID), .REV_COUNT(REV_COUNT)) fsf_supervisor_inst (
    .clk_sys(clk_sys), .rst(rst), .call_req(call_req), .call_func(call_func), .call_sp(call_sp),
    .sram_rdata(sram_rdata), .flash_done(flash_done), .flash_rdata(flash_rdata), .call_done(call_done),
    .cpu_halted(cpu_halted), .acc_out(acc_out), .x_out(x_out), .sram_req(sram_req), .flash_req(flash_req));

  fsf_flash_model fsf_flash_model_inst (
    .clk_sys(clk_sys), .slow(slow), .sram_req(sram_req), .flash_req(flash_req),
    .sram_rdata(sram_rdata), .flash_done(flash_done), .flash_rdata(flash_rdata));

  // ==========================================================
  // Clock at 40 MHz.
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic check_eq(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic do_reset;
    rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
  endtask

  // One call; key 1 is spoiled by flaw 1, key 2 by flaw 2. Waits for done or halt.
  task automatic do_call(input logic [7:0] fn, input logic [7:0] blk, input int flaw);
    logic [7:0] sp;
    sp = 8'($urandom);
    clkv = 8'($urandom);
    fsf_flash_model_inst.sram[8'hF8] = (flaw == 1) ? 8'h3B : 8'h3A;
    fsf_flash_model_inst.sram[8'hF9] = sp + 8'h03 + 8'(flaw == 2);
    fsf_flash_model_inst.sram[8'hFA] = blk;
    fsf_flash_model_inst.sram[8'hFC] = clkv;
    fsf_flash_model_inst.sram[8'hFE] = 8'h56;
    @(negedge clk_sys);
    call_req = 1'b1;
    call_func = fn;
    call_sp = sp;
    @(negedge clk_sys);
    call_req = 1'b0;
    for (int n = 0; n < 90000 && call_done !== 1'b1 && cpu_halted !== 1'b1; n++) @(negedge clk_sys);
    `CHK(call_done, flaw == 0)
    `CHK(cpu_halted, flaw != 0)
    @(negedge clk_sys);
  endtask

  function automatic logic [15:0] csum(input logic [7:0] n);
    logic [15:0] s;
    s = 16'h0000;
    for (int j = 0; j < ((n == 8'h00) ? 256 : int'(n)) * 64; j++) s = s + 16'(fsf_flash_model_inst.user[j]);
    return s;
  endfunction

  // ==========================================================
  // Watchdog cuts a hang short.
  initial begin
    repeat (150000) @(posedge clk_sys);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    test_done;
  end

  // ==========================================================
  // Main sequence.
  initial begin
    void'($urandom(62));
    for (int i = 0; i < 64; i++) fsf_flash_model_inst.tbl[i] = 8'($urandom);
    do_reset;
    `CHK({call_done, cpu_halted, flash_req.start, sram_req.we}, 0)
    `CHK({acc_out, x_out}, 0)
    // Bad first key, then bad second key, each halts for good until reset.
    for (int k = 1; k <= 2; k++) begin
      do_call(8'h04, 8'h00, k);
      do_reset;
      `CHK(cpu_halted, 0)
    end
    do_call(8'h00, 8'h00, 0);
    // An unused function code finishes at once and leaves no return code behind.
    do_call(8'h09, 8'h00, 0);
    `CHK(fsf_flash_model_inst.sram[8'hF8], 8'h3A)
    // Protect: OR of SRAM from 80h into the stored bits, bits never drop.
    for (int i = 0; i < 64; i++) begin
      fsf_flash_model_inst.prot[0][i] = (i == 0) ? 8'hFF : 8'($urandom);
      fsf_flash_model_inst.sram[8'h80 + i] = (i == 63) ? 8'hFF : 8'($urandom);
      exp_b[i] = fsf_flash_model_inst.prot[0][i] | fsf_flash_model_inst.sram[8'h80 + i];
    end
    do_call(8'h04, 8'h00, 0);
    bad = 0;
    for (int i = 0; i < 64; i++) bad += int'(fsf_flash_model_inst.prot[0][i] !== exp_b[i]);
    `CHK(bad, 0)
    `CHK(fsf_flash_model_inst.sram[8'hF8], 8'h00)
    `CHK({flash_req.clk_div, flash_req.delay}, {clkv, 8'h56})
    // Table fetch, every table number with noise in the upper bits.
    for (int t = 0; t < 8; t++) begin
      do_call(8'h06, {5'($urandom), 3'(t)}, 0);
      bad = 0;
      for (int i = 0; i < 8; i++) bad += int'(fsf_flash_model_inst.sram[8'hF8 + i] !== fsf_flash_model_inst.tbl[t * 8 + i]);
      `CHK(bad, 0)
      `CHK({acc_out, x_out}, (t == 1) ? {REV_COUNT, 8'hFF} : REV_ID)
    end
    // Checksum over one block, a random count and all 256 blocks.
    for (int j = 0; j < 16384; j++) fsf_flash_model_inst.user[j] = 8'($urandom);
    for (int c = 0; c < 3; c++) begin
      clkv = (c == 0) ? 8'h01 : (c == 1) ? 8'(2 + $urandom % 6) : 8'h00;
      slow = (c != 2);
      exp_b[0] = clkv;
      do_call(8'h07, clkv, 0);
      `CHK({fsf_flash_model_inst.sram[8'hF9], fsf_flash_model_inst.sram[8'hF8]}, csum(exp_b[0]))
    end
    slow = 1'b1;
    // Full erase over two macros: order of steps and cleared protection.
    for (int i = 0; i < 128; i++) fsf_flash_model_inst.prot[i / 64][i % 64] = 8'($urandom);
    fsf_flash_model_inst.log_q.delete();
    for (int mc = 1; mc >= 0; mc--) begin
      exp_q.push_back({3'h2, 2'(mc)});
      exp_q.push_back({3'h3, 2'(mc)});
      exp_q.push_back({3'h2, 2'(mc)});
    end
    for (int mc = 1; mc >= 0; mc--) begin
      exp_q.push_back({3'h4, 2'(mc)});
      exp_q.push_back({3'h6, 2'(mc)});
    end
    do_call(8'h05, 8'h00, 0);
    `CHK(fsf_flash_model_inst.log_q.size(), exp_q.size())
    bad = 0;
    foreach (exp_q[i]) bad += int'(fsf_flash_model_inst.log_q[i] !== exp_q[i]);
    `CHK(bad, 0)
    bad = 0;
    for (int i = 0; i < 128; i++) bad += int'(fsf_flash_model_inst.prot[i / 64][i % 64] !== 8'h00);
    for (int j = 0; j < 16384; j++) bad += int'(fsf_flash_model_inst.user[j] !== 8'hFF);
    `CHK(bad, 0)
    `CHK(fsf_flash_model_inst.sram[8'hF8], 8'h00)
    test_done;
  end
endmodule // fsf_supervisor_bench
